// file: hw/feedforward_flux_balance.sv
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// What this block does
// RULE_01 - Feed-forward input from one of four sources
// RULE_02 - Software computes override from input voltage
// RULE_03 - Input transient adjusts duty, bypassing linear loop
// RULE_04 - Writes act at once; volatile storage
// RULE_05 - Measure amplitude and pulse width each cycle
// RULE_06 - Half-cycle volt-second error drives PI trim
// RULE_07 - Balancing only full-bridge, voltage mode, lock set
// RULE_08 - Timing-only select chooses balance method
// RULE_09 - Recommended gains four and twenty-four
// RULE_10 - Suspend balancing below discontinuous-conduction threshold
// RULE_11 - Software keeps enough dead time before rectifier
// RULE_12 - Inactive balancing freezes PI, zero trim
module feedforward_flux_balance
	import ffwd_fbal_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     resetn,
	input  wire regReq_t  regReq,
	output logic [31:0]   rdData,
	input  wire senseIn_t sense,
	output pwmOut_t       pwm
);
	logic     rstSync1, rstn;
	senseIn_t senseS1, senseS2;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rstSync1 <= 1'b0;
			rstn     <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstn     <= rstSync1;
		end
	end

	// Sense pins come from the analog front end; two stages before use
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			senseS1 <= '0;
			senseS2 <= '0;
		end else begin
			senseS1 <= sense;
			senseS2 <= senseS1;
		end
	end

	// Configuration registers, live on write
	logic [31:0] ctrl_q, override_q, gains_q, dcmThr_q, ffGain_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q     <= CTRL_RST;
			override_q <= OVERRIDE_RST;
			gains_q    <= GAINS_RST;
			dcmThr_q   <= DCM_THR_RST;
			ffGain_q   <= FF_GAIN_RST;
		end else if (regReq.wr) begin // RULE_04
			case (regReq.addr)
				REG_CTRL:     ctrl_q     <= regReq.wdata;
				REG_OVERRIDE: override_q <= regReq.wdata; // RULE_02
				REG_GAINS:    gains_q    <= regReq.wdata; // RULE_09
				REG_DCM_THR:  dcmThr_q   <= regReq.wdata;
				REG_FF_GAIN:  ffGain_q   <= regReq.wdata;
				default:      ;
			endcase
		end
	end

	ffSource_t     src;
	logic          lockEn, timeOnly, balActive, dcm;
	logic [7:0]    kp, ki;
	assign src      = ffSource_t'(ctrl_q[CTRL_SRC_LSB +: 2]);
	assign lockEn   = ctrl_q[CTRL_LOCK_BIT];
	assign timeOnly = ctrl_q[CTRL_TONLY_BIT];
	assign kp       = gains_q[GAIN_KP_LSB +: 8];
	assign ki       = gains_q[GAIN_KI_LSB +: 8];

	// Feed-forward source mux
	logic [DW-1:0] ffVin_d, ffVin_q;
	always_comb begin
		case (src) // RULE_01
			SRC_PRIMARY:   ffVin_d = senseS2.primaryRect;
			SRC_SECONDARY: ffVin_d = senseS2.secondaryRect;
			SRC_TELEMETRY: ffVin_d = senseS2.telemetryVin;
			SRC_OVERRIDE:  ffVin_d = override_q[DW-1:0];
			default:       ffVin_d = senseS2.primaryRect;
		endcase
	end

	// Transient detect and duty correction: duty ~ vout/vin, step scaled
	logic signed [DW:0]   vinStep;
	logic                 ffTransient;
	logic signed [31:0]   ffCorr;
	assign vinStep     = $signed({1'b0, ffVin_d}) - $signed({1'b0, ffVin_q});
	assign ffTransient = (vinStep > $signed((DW+1)'(FF_STEP_THR)))
		|| (vinStep < -$signed((DW+1)'(FF_STEP_THR)));
	assign ffCorr = -((32'(vinStep) * $signed({20'h0, senseS2.vout}) * $signed({16'h0,
		ffGain_q[15:0]})) >>> 16);

	// Output fields get flops of their own so that each process owns its bits
	logic [15:0] dutyAdjust_q, evenTrim_q, oddTrim_q;
	logic        dutyValid_q;
	assign pwm = '{dutyAdjust: dutyAdjust_q, dutyAdjustValid: dutyValid_q,
		evenTrim: evenTrim_q, oddTrim: oddTrim_q};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ffVin_q      <= '0;
			dutyAdjust_q <= 16'h0000;
			dutyValid_q  <= 1'b0;
		end else begin
			ffVin_q      <= ffVin_d;
			dutyValid_q  <= ffTransient; // RULE_03
			dutyAdjust_q <= ffTransient ? sat16(ffCorr) : 16'h0000; // RULE_03
		end
	end

	// Pulse width in 5 ns units: coarse clock count plus fine edge code
	logic [15:0] pwCount_q;
	logic        pulseDly_q;
	logic [DW-1:0] ampPeak_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pwCount_q  <= 16'h0000;
			pulseDly_q <= 1'b0;
			ampPeak_q  <= '0;
		end else begin
			pulseDly_q <= senseS2.rectifiedPulse;
			if (senseS2.rectifiedPulse && !pulseDly_q) begin // RULE_05
				pwCount_q <= 16'(EDGE_SUBTICKS);
				ampPeak_q <= senseS2.secondaryRect;
			end else if (senseS2.rectifiedPulse) begin
				pwCount_q <= pwCount_q + 16'(EDGE_SUBTICKS);
				if (senseS2.secondaryRect > ampPeak_q)
					ampPeak_q <= senseS2.secondaryRect;
			end
		end
	end

	// Latched at half-cycle end; the edge fine code refines the width
	logic [15:0] width;
	logic [31:0] product;
	assign width   = pwCount_q + {12'h0, senseS2.edgeFine}; // RULE_05
	assign product = timeOnly ? {16'h0, width} : 32'(width) * 32'({4'h0, ampPeak_q}); // RULE_08

	logic [31:0] evenVs, oddVs;
	logic        oddSeen_q, pairReady_q;
	half_cycle_store #(.W(32)) store (
		.clk   (clk),
		.rstn  (rstn),
		.wrEn  (senseS2.halfCycleEnd),
		.wrSel (senseS2.halfCycleOdd),
		.wrData(product),
		.rdEven(evenVs),
		.rdOdd (oddVs)
	);

	// Odd half-cycle closes the pair; store read lags two cycles
	logic [1:0] pairPipe_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pairPipe_q <= 2'b00;
			oddSeen_q  <= 1'b0;
		end else begin
			pairPipe_q <= {pairPipe_q[0], senseS2.halfCycleEnd && senseS2.halfCycleOdd};
			// Remembers whether the last closed half-cycle was the odd one
			oddSeen_q  <= senseS2.halfCycleEnd ? senseS2.halfCycleOdd : oddSeen_q;
		end
	end
	assign pairReady_q = pairPipe_q[1];

	// Light load means discontinuous conduction
	assign dcm = senseS2.loadCurrent < dcmThr_q[DW-1:0]; // RULE_10
	assign balActive = lockEn && ctrl_q[CTRL_FB_BIT] && ctrl_q[CTRL_VMC_BIT] && !dcm; // RULE_07

	logic signed [31:0] err_q, integ_q, piOut;
	logic signed [31:0] errNow;
	assign errNow = $signed(evenVs) - $signed(oddVs); // RULE_06
	assign piOut  = ((errNow * $signed({24'h0, kp})) + integ_q) >>> 8;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			err_q   <= '0;
			integ_q <= '0;
		end else if (pairReady_q && balActive) begin // RULE_12
			err_q   <= errNow;
			integ_q <= integ_q + errNow * $signed({24'h0, ki}); // RULE_06
		end
	end

	// Full PI output to each side, opposite in sign, so the pair moves toward balance
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			evenTrim_q <= 16'h0000;
			oddTrim_q  <= 16'h0000;
		end else if (!balActive) begin
			evenTrim_q <= 16'h0000; // RULE_12
			oddTrim_q  <= 16'h0000; // RULE_12
		end else if (pairReady_q) begin
			evenTrim_q <= sat16(-piOut); // RULE_06
			oddTrim_q  <= sat16(piOut);
		end
	end

	// Read port: data one cycle after strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= 32'h0000_0000;
		end else if (regReq.rd) begin
			case (regReq.addr)
				REG_CTRL:     rdData <= ctrl_q;
				REG_OVERRIDE: rdData <= override_q;
				REG_GAINS:    rdData <= gains_q;
				REG_DCM_THR:  rdData <= dcmThr_q;
				REG_FF_GAIN:  rdData <= ffGain_q;
				REG_STATUS:   rdData <= {29'h0, dcm, balActive, oddSeen_q};
				REG_FF_VIN:   rdData <= {20'h0, ffVin_q};
				REG_TRIM:     rdData <= {oddTrim_q, evenTrim_q};
				REG_ERR:      rdData <= err_q;
				default:      rdData <= 32'h0000_0000;
			endcase
		end else begin
			rdData <= 32'h0000_0000;
		end
	end
endmodule // feedforward_flux_balance

// file: hw/ffwd_fbal_pkg.sv
package ffwd_fbal_pkg;

	localparam int DW = 12;
	localparam int AW = 4;

	// Register offsets
	localparam logic [AW-1:0] REG_CTRL      = 4'h0;
	localparam logic [AW-1:0] REG_OVERRIDE  = 4'h1;
	localparam logic [AW-1:0] REG_GAINS     = 4'h2;
	localparam logic [AW-1:0] REG_DCM_THR   = 4'h3;
	localparam logic [AW-1:0] REG_FF_GAIN   = 4'h4;
	localparam logic [AW-1:0] REG_STATUS    = 4'h5;
	localparam logic [AW-1:0] REG_FF_VIN    = 4'h6;
	localparam logic [AW-1:0] REG_TRIM      = 4'h7;
	localparam logic [AW-1:0] REG_ERR       = 4'h8;

	// CTRL fields
	localparam int CTRL_SRC_LSB   = 0;
	localparam int CTRL_LOCK_BIT  = 2;
	localparam int CTRL_TONLY_BIT = 3;
	localparam int CTRL_FB_BIT    = 4;
	localparam int CTRL_VMC_BIT   = 5;

	// GAINS fields
	localparam int GAIN_KP_LSB = 0;
	localparam int GAIN_KI_LSB = 8;

	// Reset values
	localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
	localparam logic [31:0] OVERRIDE_RST = 32'h0000_0000;
	localparam logic [31:0] GAINS_RST    = 32'h0000_0000;
	localparam logic [31:0] DCM_THR_RST  = 32'h0000_0010;
	localparam logic [31:0] FF_GAIN_RST  = 32'h0000_0000;

	// Edge-comparator resolution and controller clock
	localparam int EDGE_RES_PS   = 5000;
	localparam int CLK_PERIOD_PS = 50000;
	localparam int EDGE_SUBTICKS = (CLK_PERIOD_PS + EDGE_RES_PS - 1) / EDGE_RES_PS;

	// Feed-forward transient threshold in input codes
	localparam int FF_STEP_THR = 8;

	typedef enum logic [1:0] {
		SRC_PRIMARY   = 2'h0,
		SRC_SECONDARY = 2'h1,
		SRC_TELEMETRY = 2'h2,
		SRC_OVERRIDE  = 2'h3
	} ffSource_t;

	typedef struct packed {
		logic [DW-1:0] primaryRect;
		logic [DW-1:0] secondaryRect;
		logic [DW-1:0] telemetryVin;
		logic [DW-1:0] vout;
		logic          halfCycleOdd;
		logic          halfCycleEnd;
		logic          rectifiedPulse;
		logic [3:0]    edgeFine;
		logic [DW-1:0] loadCurrent;
	} senseIn_t;

	typedef struct packed {
		logic [15:0] dutyAdjust;
		logic        dutyAdjustValid;
		logic [15:0] evenTrim;
		logic [15:0] oddTrim;
	} pwmOut_t;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [31:0]   wdata;
		logic          wr;
		logic          rd;
	} regReq_t;

	function automatic logic [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767)
			return 16'h7FFF;
		else if (v < -32'sd32768)
			return 16'h8000;
		else
			return v[15:0];
	endfunction

endpackage

// file: hw/half_cycle_store.sv
`timescale 1ns/1ps
// Two-entry store for the last even and odd volt-second products
module half_cycle_store #(
	parameter int W = 32
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         wrEn,
	input  wire logic         wrSel,
	input  wire logic [W-1:0] wrData,
	output logic      [W-1:0] rdEven,
	output logic      [W-1:0] rdOdd
);
	logic [W-1:0] mem [2];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (wrEn) begin
			mem[wrSel] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdEven <= '0;
			rdOdd  <= '0;
		end else begin
			rdEven <= mem[0];
			rdOdd  <= mem[1];
		end
	end
endmodule // half_cycle_store

// file: tb/feedforward_flux_balance_tb_top.sv
`timescale 1ns/1ps
module feedforward_flux_balance_tb_top
	import ffwd_fbal_pkg::*;
;
	logic        clk;
	logic        resetn;
	regReq_t     req;
	logic [31:0] rdData;
	senseIn_t    sns;
	senseIn_t    sense;
	pwmOut_t     pwm;
	logic        run;
	logic        pulse;
	logic        odd;
	logic        halfEnd;
	logic [31:0] v;
	int          error_cnt = 0;
	int          compares = 0;
	int          cyc = 0;
	logic [AW-1:0] ra [6] = '{REG_CTRL, REG_OVERRIDE, REG_GAINS, REG_DCM_THR, REG_FF_GAIN, 4'hF};
	logic [31:0]   rv [6] = '{CTRL_RST, OVERRIDE_RST, GAINS_RST, DCM_THR_RST, FF_GAIN_RST, 32'h0};
	logic [11:0]   sv [4] = '{12'h100, 12'h200, 12'h300, 12'h39C};
	feedforward_flux_balance DUT (.clk(clk), .resetn(resetn), .regReq(req), .rdData(rdData),
		.sense(sense), .pwm(pwm));
	power_stage_model stage (.clk(clk), .run(run), .evenW(4'h8), .oddW(4'h5), .pulse(pulse),
		.odd(odd), .halfEnd(halfEnd));
	always_comb begin
		sense = sns;
		sense.rectifiedPulse = pulse;
		sense.halfCycleOdd = odd;
		sense.halfCycleEnd = halfEnd;
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			error_cnt++;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		d = rdData;
	endtask
	task automatic ffStep(input logic [11:0] x, input logic e);
		logic        h;
		logic [15:0] a;
		h = 1'b0;
		a = 16'h0000;
		@(posedge clk);
		sns.primaryRect <= x;
		repeat (6) begin
			@(negedge clk);
			h = h | (pwm.dutyAdjustValid === 1'b1);
			a = a | pwm.dutyAdjust;
		end
		cmp("dutyAdjustValid", {31'h0, e}, {31'h0, h});
		// A rising input step above the transient threshold, with nonzero gain, must pull the duty down
		cmp("dutyAdjustSign", {31'h0, e}, {31'h0, a[15]});
	endtask
	task automatic trimPos(input string n);
		@(negedge clk);
		cmp(n, 32'h1, {31'h0, $signed(pwm.oddTrim) > 0 && pwm.evenTrim === -pwm.oddTrim});
	endtask
	initial begin
		resetn = 1'b0;
		req = '0;
		run = 1'b0;
		sns = '{12'h100, 12'h200, 12'h300, 12'h080, 1'b0, 1'b0, 1'b0, 4'h0, 12'h100};
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rd(ra[i], v);
			cmp("resetValue", rv[i], v);
		end
		$display("test reset values done");
		wr(REG_OVERRIDE, 32'h0000_039C);
		for (int s = 3; s >= 0; s--) begin
			wr(REG_CTRL, 32'(s));
			repeat (4) @(posedge clk);
			rd(REG_FF_VIN, v);
			cmp("ffVin", {20'h0, sv[s]}, v);
		end
		$display("test sources done");
		wr(REG_FF_GAIN, 32'h0000_4000);
		repeat (10) @(posedge clk);
		ffStep(12'h108, 1'b0);
		ffStep(12'h111, 1'b1);
		$display("test transient done");
		wr(REG_GAINS, 32'h0000_1804);
		wr(REG_CTRL, 32'h0000_0038);
		run <= 1'b1;
		repeat (100) @(posedge clk);
		@(negedge clk);
		cmp("trimUnlocked", 32'h0, {16'h0, pwm.oddTrim});
		wr(REG_CTRL, 32'h0000_003C);
		repeat (100) @(posedge clk);
		rd(REG_ERR, v);
		cmp("errTime", 32'h0000_001E, v);
		trimPos("trimTime");
		wr(REG_CTRL, 32'h0000_0034);
		repeat (100) @(posedge clk);
		rd(REG_ERR, v);
		// Width gap of 30 fine units times the steady amplitude of 0x200
		cmp("errVs", 32'h0000_3C00, v);
		$display("test balance done");
		sns.loadCurrent <= 12'h00F;
		repeat (20) @(posedge clk);
		@(negedge clk);
		cmp("trimDcm", 32'h0, {16'h0, pwm.oddTrim});
		rd(REG_STATUS, v);
		cmp("dcmFlag", 32'h1, {31'h0, v[2]});
		sns.loadCurrent <= 12'h100;
		repeat (100) @(posedge clk);
		trimPos("trimResume");
		$display("test dcm done");
		wr(REG_CTRL, 32'h0000_0024);
		repeat (3) @(negedge clk);
		cmp("trimHalfBridge", 32'h0, {16'h0, pwm.oddTrim});
		wr(REG_CTRL, 32'h0000_0034);
		repeat (100) @(posedge clk);
		trimPos("trimRelock");
		rd(REG_STATUS, v);
		cmp("balActive", 32'h1, {31'h0, v[1]});
		wr(REG_CTRL, 32'h0000_0030);
		repeat (3) @(negedge clk);
		cmp("trimLockOff", 32'h0, {16'h0, pwm.evenTrim});
		rd(REG_STATUS, v);
		cmp("balIdle", 32'h0, {31'h0, v[1]});
		$display("test mode and lock done");
		results();
	end
endmodule // feedforward_flux_balance_tb_top

// file: tb/ffwd_fbal_properties.sv
`timescale 1ns/1ps
module ffwd_fbal_checker
	import ffwd_fbal_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire regReq_t     regReq,
	input wire logic [31:0] rdData,
	input wire senseIn_t    sense,
	input wire pwmOut_t     pwm
);
	logic [31:0] ctrlQ;
	logic [31:0] thrQ;
	logic        wrC;
	logic        wrT;
	assign wrC = regReq.wr && regReq.addr == REG_CTRL;
	assign wrT = regReq.wr && regReq.addr == REG_DCM_THR;
	// Shadows of the config words that gate the trim
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrlQ <= CTRL_RST;
			thrQ  <= DCM_THR_RST;
		end else begin
			ctrlQ <= wrC ? regReq.wdata : ctrlQ;
			thrQ  <= wrT ? regReq.wdata : thrQ;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_rd_idle_zero: assert property (!$past(regReq.rd) |-> rdData == 32'h0)
		else $error("rdData not zero when idle");
	chk_unmapped_read: assert property (regReq.rd && regReq.addr > REG_ERR |=> rdData == 32'h0)
		else $error("unmapped read not zero");
	chk_ctrl_readback: assert property (regReq.rd && regReq.addr == REG_CTRL
		|=> rdData[5:0] == ctrlQ[5:0]) else $error("ctrl readback wrong");
	chk_lock_trim: assert property (!ctrlQ[CTRL_LOCK_BIT] && !$past(ctrlQ[CTRL_LOCK_BIT], 4)
		|-> pwm.evenTrim == 16'h0 && pwm.oddTrim == 16'h0) else $error("trim without lock");
	chk_mode_trim: assert property (!(ctrlQ[4] && ctrlQ[5]) && !$past(ctrlQ[4] && ctrlQ[5], 4)
		|-> pwm.oddTrim == 16'h0) else $error("trim outside full bridge vmc");
	chk_dcm_trim: assert property ((sense.loadCurrent < thrQ[DW-1:0])[*6]
		|-> pwm.oddTrim == 16'h0 && pwm.evenTrim == 16'h0) else $error("trim in dcm");
	chk_trim_sym: assert property (16'(pwm.evenTrim + pwm.oddTrim) == 16'h0)
		else $error("trims not opposite");
	chk_ff_pulse: assert property (pwm.dutyAdjustValid |=> !pwm.dutyAdjustValid)
		else $error("duty adjust too long");
	chk_status_act: assert property (regReq.rd && regReq.addr == REG_STATUS
		&& !ctrlQ[CTRL_LOCK_BIT] |=> !rdData[1]) else $error("active without lock");
endmodule // ffwd_fbal_checker
bind feedforward_flux_balance ffwd_fbal_checker u_chk (.clk(clk), .resetn(resetn),
	.regReq(regReq), .rdData(rdData), .sense(sense), .pwm(pwm));

// file: tb/power_stage_model.sv
`timescale 1ns/1ps
// Half cycles of 16 clocks, each with a rectified pulse of its own width
module power_stage_model (
	input  wire logic       clk,
	input  wire logic       run,
	input  wire logic [3:0] evenW,
	input  wire logic [3:0] oddW,
	output logic            pulse,
	output logic            odd,
	output logic            halfEnd
);
	logic [3:0] cnt;
	always @(posedge clk) begin
		if (!run) begin
			cnt     <= 4'h0;
			pulse   <= 1'b0;
			odd     <= 1'b0;
			halfEnd <= 1'b0;
		end else begin
			cnt     <= cnt + 4'h1;
			// Widths under 15 leave dead time before the half-cycle end
			pulse   <= cnt < (odd ? oddW : evenW);
			halfEnd <= cnt == 4'hF;
			odd     <= halfEnd ? !odd : odd;
		end
	end
endmodule // power_stage_model
